/* prmc_pkg.sv */
// Constants, register map and types of the power reduction mode controller
package prmc_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] PRMC_IDX_POWER_CONTROL_REG = 10'h087; // power_control_reg
  localparam logic [9:0] PRMC_IDX_POWER_CONTROL_AUX_REG = 10'h0B5; // power_control_aux_reg
  localparam logic [9:0] PRMC_IDX_CFG = 10'h0C0; // wake and clock configuration
  localparam logic [9:0] PRMC_IDX_STAT = 10'h0C1; // controller status
  localparam int PRMC_AW = 12; // Bus address width
  // ----------------------------------------------------------------
  // Mode field codes
  // ----------------------------------------------------------------
  localparam logic [1:0] PRMC_MODE_NORMAL = 2'h0;
  localparam logic [1:0] PRMC_MODE_IDLE = 2'h1;
  localparam logic [1:0] PRMC_MODE_PDOWN = 2'h2;
  localparam logic [1:0] PRMC_MODE_TOTAL = 2'h3;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PRMC_POWER_CONTROL_REG_BOI = 4; // Brownout gives interrupt, not reset
  localparam int PRMC_POWER_CONTROL_REG_BOPD = 5; // Brownout detector powered down
  localparam int PRMC_POWER_CONTROL_AUX_REG_CMPPD = 5; // Comparator power-down
  localparam int PRMC_POWER_CONTROL_AUX_REG_RTC_POWER_DOWN = 7; // rtc_power_down
  localparam int PRMC_CFG_GIE = 7; // global_irq_enable
  localparam int PRMC_CFG_WDTRST = 8; // Watchdog event is a reset
  localparam int PRMC_CFG_WATCHDOG_CLOCK_SELECT = 9; // watchdog_clock_select
  localparam int PRMC_CFG_CLK = 10; // Two-bit clock source field
  localparam int PRMC_CFG_RTCEN = 12; // Real-time clock enabled
  localparam int PRMC_CFG_CMPEN = 13; // Comparators enabled
  localparam int PRMC_CFG_BOE = 14; // Brownout detector fitted/enabled
  // ----------------------------------------------------------------
  // Wake source lanes
  // ----------------------------------------------------------------
  localparam int PRMC_NSRC = 7;
  localparam int PRMC_SRC_EXT0 = 0;
  localparam int PRMC_SRC_EXT1 = 1;
  localparam int PRMC_SRC_BOD = 2;
  localparam int PRMC_SRC_KBD = 3;
  localparam int PRMC_SRC_RTC = 4;
  localparam int PRMC_SRC_WDT = 5;
  localparam int PRMC_SRC_CMP = 6;
  // ----------------------------------------------------------------
  // Clock sources, start-up counts, resets, responses
  // ----------------------------------------------------------------
  localparam logic [1:0] PRMC_CLK_XTAL = 2'h0;
  localparam logic [1:0] PRMC_CLK_RC = 2'h1;
  localparam int PRMC_START_XTAL = 1024; // Clocks after crystal restart
  localparam int PRMC_START_RC = 256; // Clocks after RC/external restart
  localparam logic [7:0] PRMC_POWER_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] PRMC_POWER_CONTROL_AUX_REG_RST = 8'h00;
  localparam logic [15:0] PRMC_CFG_RST = 16'h0000;
  localparam logic [1:0] PRMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PRMC_RESP_SLVERR = 2'h2;
  // Controller states
  typedef enum logic [1:0] {PRMC_ST_NORMAL, PRMC_ST_IDLE, PRMC_ST_PDOWN,
                            PRMC_ST_STARTUP} prmc_state_t;
  // Register selector
  typedef enum logic [2:0] {PRMC_SEL_NONE, PRMC_SEL_POWER_CONTROL_REG, PRMC_SEL_POWER_CONTROL_AUX_REG,
                            PRMC_SEL_CFG, PRMC_SEL_STAT} prmc_sel_t;
endpackage

/* prmc_cnt_if.sv */
// Link between the mode controller and its start-up counter
`timescale 1ns/1ps
interface prmc_cnt_if;
  logic start; // Load pulse on wake from power-down
  logic long_sel; // High for crystal count, low for short count
  logic busy; // Counting in progress
  logic done; // Last counted clock
  modport ctrl (output start, output long_sel, input busy, input done);
  modport cnt (input start, input long_sel, output busy, output done);
endinterface

/* prmc_startup_cnt.sv */
// Oscillator start-up counter of the power reduction mode controller
`timescale 1ns/1ps
module prmc_startup_cnt import prmc_pkg::*; #(
  parameter int LONG_CNT = PRMC_START_XTAL,
  parameter int SHORT_CNT = PRMC_START_RC
) (
  input wire logic clk,
  input wire logic resetn,
  prmc_cnt_if.cnt cif
);
  localparam int CW = $clog2(LONG_CNT + 1);
  logic [CW-1:0] cnt_q; // Clocks still to count, minus one
  logic busy_q; // Counter running

  // ----------------------------------------------------------------
  // Down counter, loaded on start
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cnt_q <= '0;
      busy_q <= 1'b0;
    end else if (cif.start) begin
      // Crystal needs the long count, RC and external input the short one
      cnt_q <= cif.long_sel ? CW'(LONG_CNT - 1) : CW'(SHORT_CNT - 1);
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (cnt_q == '0) begin
        busy_q <= 1'b0;
      end else begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign cif.busy = busy_q;
  assign cif.done = busy_q && (cnt_q == '0);
endmodule

/* prmc_ctrl.sv */
// Power reduction mode controller with AXI4-Lite register slave
// Function
// - Two-bit field selects normal, idle, power-down
// - Idle keeps peripherals; enabled interrupt/reset ends
// - Power-down stops the system oscillator unless the RTC runs from it
// - Listed sources or reset end power-down
// - Reset wakes only when that reset enabled
// - Interrupt wakes needs own and global enable
// - RC oscillator off unless RC clock plus RTC
// - Crystal wake holds execution 1024 clocks
// - RC or external wake holds 256 clocks
// - Brownout stays on; watchdog runs if selected
// - Comparators powered unless bit set and disabled
// - RTC and its crystal run unless RTC pd
// - Code 11 also kills brownout and comparators
`timescale 1ns/1ps
module prmc_ctrl import prmc_pkg::*; (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [PRMC_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PRMC_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [PRMC_NSRC-1:0] wake_src,
  output logic sys_osc_on,
  output logic rc_osc_on,
  output logic cpu_clk_on,
  output logic periph_clk_on,
  output logic exec_hold,
  output logic brownout_on,
  output logic comparator_pwr,
  output logic watchdog_run,
  output logic rtc_run,
  output logic wake_reset
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  prmc_state_t state_q; // Controller state
  logic [7:0] power_control_reg_q; // power_control_reg
  logic [7:0] power_control_aux_reg_q; // power_control_aux_reg
  logic [15:0] cfg_q; // Wake and clock configuration
  logic [PRMC_NSRC-1:0] sync_a_q; // First synchroniser stage
  logic [PRMC_NSRC-1:0] sync_b_q; // Second synchroniser stage
  logic [PRMC_NSRC-1:0] last_wake_q; // Sources seen at last wake
  logic [PRMC_AW-1:0] awaddr_q; // Held write address
  logic [PRMC_AW-1:0] araddr_w; // Read address alias
  logic [31:0] wdata_q; // Held write data
  logic [3:0] wstrb_q; // Held write strobes
  logic wr_fire; // Both write halves present
  prmc_sel_t wr_sel; // Write target
  logic [1:0] mode; // Current mode field
  logic bod_active; // Brownout detector enabled
  logic rtc_alive; // RTC keeps running in power-down
  logic [PRMC_NSRC-1:0] irq_en; // Source enable gated by global
  logic [PRMC_NSRC-1:0] pd_live; // Sources alive in power-down
  logic rst_idle; // Enabled reset during idle
  logic rst_pd; // Enabled reset during power-down
  logic idle_wake; // Idle terminates
  logic pd_wake; // Power-down terminates
  logic pd_now; // In power-down
  prmc_cnt_if cif (); // Start-up counter link

  // Map a word address onto a register
  function automatic prmc_sel_t prmc_decode(input logic [PRMC_AW-1:0] addr);
    unique case (addr[PRMC_AW-1:2])
      PRMC_IDX_POWER_CONTROL_REG: prmc_decode = PRMC_SEL_POWER_CONTROL_REG;
      PRMC_IDX_POWER_CONTROL_AUX_REG: prmc_decode = PRMC_SEL_POWER_CONTROL_AUX_REG;
      PRMC_IDX_CFG: prmc_decode = PRMC_SEL_CFG;
      PRMC_IDX_STAT: prmc_decode = PRMC_SEL_STAT;
      default: prmc_decode = PRMC_SEL_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Wake input synchroniser
  // ----------------------------------------------------------------
  // Sources come from other blocks and pins, so two stages first
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_a_q <= '0;
      sync_b_q <= '0;
    end else begin
      sync_a_q <= wake_src;
      sync_b_q <= sync_a_q;
    end
  end

  // ----------------------------------------------------------------
  // Wake qualification
  // ----------------------------------------------------------------
  assign mode = power_control_reg_q[1:0];
  assign pd_now = (state_q == PRMC_ST_PDOWN);
  // Code 11 silences the brownout detector outright
  assign bod_active = cfg_q[PRMC_CFG_BOE] && !power_control_reg_q[PRMC_POWER_CONTROL_REG_BOPD] &&
                      (mode != PRMC_MODE_TOTAL);
  assign rtc_alive = cfg_q[PRMC_CFG_RTCEN] && !power_control_aux_reg_q[PRMC_POWER_CONTROL_AUX_REG_RTC_POWER_DOWN];
  assign irq_en = cfg_q[PRMC_NSRC-1:0] & {PRMC_NSRC{cfg_q[PRMC_CFG_GIE]}};

  // Which sources can still fire while the oscillator is down
  always_comb begin
    pd_live = '0;
    pd_live[PRMC_SRC_EXT0] = 1'b1;
    pd_live[PRMC_SRC_EXT1] = 1'b1;
    pd_live[PRMC_SRC_KBD] = 1'b1;
    pd_live[PRMC_SRC_BOD] = bod_active && power_control_reg_q[PRMC_POWER_CONTROL_REG_BOI];
    pd_live[PRMC_SRC_RTC] = rtc_alive;
    pd_live[PRMC_SRC_WDT] = cfg_q[PRMC_CFG_WATCHDOG_CLOCK_SELECT];
    pd_live[PRMC_SRC_CMP] = (mode != PRMC_MODE_TOTAL);
  end

  // Resets: watchdog when set to reset, brownout when not interrupting
  assign rst_idle = (sync_b_q[PRMC_SRC_WDT] && cfg_q[PRMC_CFG_WDTRST]) ||
                    (sync_b_q[PRMC_SRC_BOD] && bod_active && !power_control_reg_q[PRMC_POWER_CONTROL_REG_BOI]);
  assign rst_pd = (sync_b_q[PRMC_SRC_WDT] && cfg_q[PRMC_CFG_WDTRST] &&
                   cfg_q[PRMC_CFG_WATCHDOG_CLOCK_SELECT]) ||
                  (sync_b_q[PRMC_SRC_BOD] && bod_active &&
                   !power_control_reg_q[PRMC_POWER_CONTROL_REG_BOI]);
  assign idle_wake = (|(sync_b_q & irq_en)) || rst_idle;
  assign pd_wake = (|(sync_b_q & irq_en & pd_live)) || rst_pd;

  // ----------------------------------------------------------------
  // Start-up counter
  // ----------------------------------------------------------------
  assign cif.start = pd_now && pd_wake;
  assign cif.long_sel = (cfg_q[PRMC_CFG_CLK +: 2] == PRMC_CLK_XTAL);

  prmc_startup_cnt #(
    .LONG_CNT(PRMC_START_XTAL),
    .SHORT_CNT(PRMC_START_RC)
  ) u_cnt (
    .clk(clk),
    .resetn(resetn),
    .cif(cif)
  );

  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= PRMC_ST_NORMAL;
    end else begin
      unique case (state_q)
        PRMC_ST_NORMAL: begin
          // Entry follows the field as soon as it is written
          if (mode == PRMC_MODE_IDLE) begin
            state_q <= PRMC_ST_IDLE;
          end else if (mode[1]) begin
            state_q <= PRMC_ST_PDOWN;
          end
        end
        PRMC_ST_IDLE: begin
          if (idle_wake) begin
            state_q <= PRMC_ST_NORMAL;
          end
        end
        PRMC_ST_PDOWN: begin
          if (pd_wake) begin
            state_q <= PRMC_ST_STARTUP;
          end
        end
        PRMC_ST_STARTUP: begin
          // Execution waits for the oscillator count to finish
          if (cif.done) begin
            state_q <= PRMC_ST_NORMAL;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wr_sel = prmc_decode(awaddr_q);

  // Mode field: a software write in the wake cycle wins over the clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_control_reg_q <= PRMC_POWER_CONTROL_REG_RST;
    end else if (wr_fire && wr_sel == PRMC_SEL_POWER_CONTROL_REG && wstrb_q[0]) begin
      power_control_reg_q <= wdata_q[7:0];
    end else if ((state_q == PRMC_ST_IDLE && idle_wake) || cif.start) begin
      power_control_reg_q[1:0] <= PRMC_MODE_NORMAL;
    end
  end

  // Auxiliary power control
  always_ff @(posedge clk) begin
    if (!resetn) begin
      power_control_aux_reg_q <= PRMC_POWER_CONTROL_AUX_REG_RST;
    end else if (wr_fire && wr_sel == PRMC_SEL_POWER_CONTROL_AUX_REG && wstrb_q[0]) begin
      power_control_aux_reg_q <= wdata_q[7:0];
    end
  end

  // Configuration, two byte lanes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cfg_q <= PRMC_CFG_RST;
    end else if (wr_fire && wr_sel == PRMC_SEL_CFG) begin
      if (wstrb_q[0]) begin
        cfg_q[7:0] <= wdata_q[7:0];
      end
      if (wstrb_q[1]) begin
        cfg_q[15:8] <= wdata_q[15:8];
      end
    end
  end

  // Sources active at the last wake, enabled or not, for software to inspect
  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_wake_q <= '0;
    end else if ((state_q == PRMC_ST_IDLE && idle_wake) || cif.start) begin
      last_wake_q <= sync_b_q;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  // One write at a time; readies drop while a write is held
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PRMC_RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        // Status is read-only; unmapped writes are refused too
        s_axi_bresp <= (wr_sel == PRMC_SEL_NONE || wr_sel == PRMC_SEL_STAT) ?
                       PRMC_RESP_SLVERR : PRMC_RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign araddr_w = s_axi_araddr;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PRMC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= PRMC_RESP_OKAY;
      unique case (prmc_decode(araddr_w))
        PRMC_SEL_POWER_CONTROL_REG: s_axi_rdata <= {24'h000000, power_control_reg_q};
        PRMC_SEL_POWER_CONTROL_AUX_REG: s_axi_rdata <= {24'h000000, power_control_aux_reg_q};
        PRMC_SEL_CFG: s_axi_rdata <= {16'h0000, cfg_q};
        PRMC_SEL_STAT: s_axi_rdata <= {22'h000000, last_wake_q, cif.busy, state_q};
        default: begin
          s_axi_rdata <= '0;
          s_axi_rresp <= PRMC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Clock and power enables
  // ----------------------------------------------------------------
  // Registered from state and settings, so they trail them by one clock
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sys_osc_on <= 1'b1;
      rc_osc_on <= 1'b1;
      cpu_clk_on <= 1'b1;
      periph_clk_on <= 1'b1;
      exec_hold <= 1'b0;
      brownout_on <= 1'b0;
      comparator_pwr <= 1'b1;
      watchdog_run <= 1'b1;
      rtc_run <= 1'b0;
      wake_reset <= 1'b0;
    end else begin
      // Crystal stays up in power-down only when the RTC runs from it
      sys_osc_on <= !pd_now ||
                    (rtc_alive && cfg_q[PRMC_CFG_CLK +: 2] == PRMC_CLK_XTAL);
      rc_osc_on <= !pd_now ||
                   (rtc_alive && cfg_q[PRMC_CFG_CLK +: 2] == PRMC_CLK_RC);
      cpu_clk_on <= (state_q == PRMC_ST_NORMAL);
      periph_clk_on <= (state_q == PRMC_ST_NORMAL) || (state_q == PRMC_ST_IDLE);
      exec_hold <= (state_q != PRMC_ST_NORMAL);
      brownout_on <= bod_active;
      comparator_pwr <= !(pd_now && ((mode == PRMC_MODE_TOTAL) ||
                        (power_control_aux_reg_q[PRMC_POWER_CONTROL_AUX_REG_CMPPD] && !cfg_q[PRMC_CFG_CMPEN])));
      watchdog_run <= !pd_now || cfg_q[PRMC_CFG_WATCHDOG_CLOCK_SELECT];
      rtc_run <= cfg_q[PRMC_CFG_RTCEN] && (!pd_now || rtc_alive);
      wake_reset <= (state_q == PRMC_ST_IDLE && rst_idle) || (pd_now && rst_pd);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [10:0] hold_cnt_q; // Clocks in start-up; long holds counted, not delayed
  always_ff @(posedge clk) begin
    if (!resetn || state_q != PRMC_ST_STARTUP) begin
      hold_cnt_q <= '0;
    end else begin
      hold_cnt_q <= hold_cnt_q + 1'b1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  a_mode_entry: assert property ((state_q == PRMC_ST_NORMAL && mode == PRMC_MODE_IDLE) |=>
    state_q == PRMC_ST_IDLE) else $error("idle not entered");
  a_idle_exit: assert property ((state_q == PRMC_ST_IDLE && idle_wake) |=>
    (state_q == PRMC_ST_NORMAL) ##1 periph_clk_on) else $error("idle exit wrong");
  a_pd_osc_off: assert property ((pd_now && !rtc_alive) |=> !sys_osc_on && !cpu_clk_on)
    else $error("oscillator runs in power-down");
  a_pd_gated: assert property ((pd_now && !pd_wake) |=> pd_now)
    else $error("power-down left without wake");
  a_rst_gate: assert property ((pd_now && sync_b_q == (1 << PRMC_SRC_WDT) &&
    !cfg_q[PRMC_CFG_WATCHDOG_CLOCK_SELECT]) |=> pd_now) else $error("stopped watchdog woke device");
  a_xtal_hold: assert property ((state_q == PRMC_ST_STARTUP && cif.long_sel &&
    hold_cnt_q < 11'(PRMC_START_XTAL - 1)) |=> (state_q == PRMC_ST_STARTUP))
    else $error("crystal start-up cut short");
  a_rc_hold: assert property ((state_q == PRMC_ST_STARTUP && cif.done) |->
    hold_cnt_q == (cif.long_sel ? 11'(PRMC_START_XTAL - 1) : 11'(PRMC_START_RC - 1)))
    else $error("start-up count wrong");
  a_rc_osc_off: assert property ((pd_now && !rtc_alive) |=> !rc_osc_on)
    else $error("rc oscillator left on");
  a_total_off: assert property ((mode == PRMC_MODE_TOTAL) |=> !brownout_on)
    else $error("brownout active in total power-down");
  a_cmp_pwr: assert property ((pd_now && mode == PRMC_MODE_PDOWN &&
    !power_control_aux_reg_q[PRMC_POWER_CONTROL_AUX_REG_CMPPD]) |=> comparator_pwr) else $error("comparator unpowered");
  a_wdt_run: assert property ((pd_now && cfg_q[PRMC_CFG_WATCHDOG_CLOCK_SELECT]) |=> watchdog_run)
    else $error("watchdog stopped");
  a_rtc_run: assert property ((pd_now && rtc_alive) |=> rtc_run)
    else $error("rtc stopped");
  a_mode_clear: assert property (cif.start && !wr_fire |=> mode == PRMC_MODE_NORMAL)
    else $error("mode not cleared on wake");

  c_idle_wake: cover property (state_q == PRMC_ST_IDLE ##1 state_q == PRMC_ST_NORMAL);
  c_xtal_wake: cover property (cif.start && cif.long_sel);
  c_rc_wake: cover property (cif.start && !cif.long_sel);
  c_reset_wake: cover property (pd_now && rst_pd);
endmodule

/* prmc_wake_model.sv */
// Wake source model: level requests held until the core resumes
`timescale 1ns/1ps
module prmc_wake_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic exec_hold,
  input wire logic [6:0] fire,
  output logic [6:0] wake_src
);
  // Level held until serviced; an edge pulse could be lost in power-down
  always_ff @(posedge clk) begin
    if (!resetn || !exec_hold) begin
      wake_src <= 7'h00;
    end else begin
      wake_src <= wake_src | fire;
    end
  end
endmodule

/* power_reduction_mode_control_bench.sv */
// Self-checking bench of the power reduction mode controller
`timescale 1ns/1ps
module power_reduction_mode_control_bench import prmc_pkg::*; ();
  logic clk, resetn, awv, awr, wv, wr, bv, brdy, arv, arr, rv, rrdy;
  logic aw_hs, w_hs, b_hs, ar_hs, r_hs; // Handshakes seen at last edge
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_q;
  logic [1:0] bresp, rresp, rr_q;
  logic [6:0] fire, wake_src;
  logic sys_osc_on, rc_osc_on, cpu_clk_on, periph_clk_on, exec_hold;
  logic brownout_on, comparator_pwr, watchdog_run, rtc_run, wake_reset;
  int bad_count, n_checks, n, n_rst;
  localparam logic [11:0] A_POWER_CONTROL_REG = {PRMC_IDX_POWER_CONTROL_REG, 2'h0};
  localparam logic [11:0] A_CFG = {PRMC_IDX_CFG, 2'h0};
  prmc_ctrl i_prmc_ctrl (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rrdy), .wake_src(wake_src), .sys_osc_on(sys_osc_on),
    .rc_osc_on(rc_osc_on), .cpu_clk_on(cpu_clk_on), .periph_clk_on(periph_clk_on),
    .exec_hold(exec_hold), .brownout_on(brownout_on), .comparator_pwr(comparator_pwr),
    .watchdog_run(watchdog_run), .rtc_run(rtc_run), .wake_reset(wake_reset));
  prmc_wake_model i_prmc_wake_model (.clk(clk), .resetn(resetn), .exec_hold(exec_hold),
    .fire(fire), .wake_src(wake_src));
  // ------------------------------------------------------------
  // Bus helpers
  // ------------------------------------------------------------
  // Capture handshakes at the edge so tasks never race the flops
  always @(posedge clk) begin
    aw_hs <= awv && awr;
    w_hs <= wv && wr;
    b_hs <= bv && brdy;
    ar_hs <= arv && arr;
    r_hs <= rv && rrdy;
    if (rv && rrdy) rd_q <= rdata;
    if (rv && rrdy) rr_q <= rresp;
    // Count reset-caused wakes for the reset wake scenario
    if (!resetn) n_rst <= 0;
    else if (wake_reset) n_rst <= n_rst + 1;
  end
  task tick;
    @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task axi_wr(input logic [11:0] a, input logic [31:0] d);
    tick;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    n = 0;
    do begin
      tick;
      if (aw_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
      n++;
    end while (!b_hs && n < 50);
    brdy <= 1'b0;
    if (!b_hs) bad_count++;
    if (!b_hs) complete_run;
  endtask
  task axi_rd(input logic [11:0] a);
    tick;
    araddr <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    n = 0;
    do begin
      tick;
      if (ar_hs) arv <= 1'b0;
      n++;
    end while (!r_hs && n < 50);
    rrdy <= 1'b0;
    if (!r_hs) bad_count++;
    if (!r_hs) complete_run;
  endtask
  // Raise a source, count clocks until execution is released
  task wake_count(input logic [6:0] src, input int lo);
    fire <= src;
    tick;
    fire <= 7'h00;
    n = 1;
    while (exec_hold === 1'b1 && n < 3000) begin
      tick;
      n++;
    end
    chk("hold clocks in range", 32'(n >= lo && n <= lo + 8), 32'h1);
    axi_rd(A_POWER_CONTROL_REG);
    chk("mode after wake", rd_q & 32'h3, 32'h0);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_reset;
    chk("cpu clock", cpu_clk_on, 1'b1);
    axi_rd(A_POWER_CONTROL_REG);
    chk("mode default", rd_q, 32'h0);
    axi_rd(12'h000);
    chk("unmapped resp", rr_q, PRMC_RESP_SLVERR);
  endtask
  task t_idle;
    axi_wr(A_CFG, 32'h0000_0081);
    axi_wr(A_POWER_CONTROL_REG, 32'h0000_0001);
    repeat (3) tick;
    chk("idle cpu clock", cpu_clk_on, 1'b0);
    chk("idle periph clock", periph_clk_on, 1'b1);
    wake_count(7'h01, 1);
  endtask
  task t_pd_xtal;
    axi_wr(A_POWER_CONTROL_REG, 32'h0000_0002);
    repeat (3) tick;
    chk("pd osc", sys_osc_on, 1'b0);
    chk("pd rc osc", rc_osc_on, 1'b0);
    chk("pd watchdog", watchdog_run, 1'b0);
    fire <= 7'h08;
    tick;
    fire <= 7'h00;
    repeat (10) tick;
    chk("disabled source ignored", exec_hold, 1'b1);
    wake_count(7'h01, PRMC_START_XTAL);
  endtask
  task t_pd_rc;
    axi_wr(A_CFG, 32'h0000_1491);
    axi_wr(A_POWER_CONTROL_REG, 32'h0000_0002);
    repeat (3) tick;
    chk("rc kept for rtc", rc_osc_on, 1'b1);
    chk("rtc runs", rtc_run, 1'b1);
    wake_count(7'h10, PRMC_START_RC);
  endtask
  task t_total;
    axi_wr(A_CFG, 32'h0000_4081);
    repeat (3) tick;
    chk("brownout on", brownout_on, 1'b1);
    axi_wr(A_POWER_CONTROL_REG, 32'h0000_0003);
    repeat (3) tick;
    chk("total brownout", brownout_on, 1'b0);
    chk("total comparator", comparator_pwr, 1'b0);
    wake_count(7'h01, PRMC_START_XTAL);
  endtask
  // Watchdog reset wakes only once its clock keeps it alive in power-down
  task t_rst_wake;
    axi_wr(A_CFG, 32'h0000_0100);
    axi_wr(A_POWER_CONTROL_REG, 32'h0000_0002);
    repeat (3) tick;
    fire <= 7'h20;
    tick;
    fire <= 7'h00;
    repeat (10) tick;
    chk("stopped watchdog held", exec_hold, 1'b1);
    chk("no reset wake yet", n_rst, 32'h0);
    axi_wr(A_CFG, 32'h0000_0300);
    wake_count(7'h20, PRMC_START_XTAL);
    chk("reset wake flagged", n_rst, 32'h1);
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Main sequence: reset held three clocks, then each scenario
  initial begin
    {resetn, awv, wv, brdy, arv, rrdy} = 6'h00;
    {awaddr, araddr, wdata, fire} = '0;
    bad_count = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    tick;
    t_reset;
    t_idle;
    t_pd_xtal;
    t_pd_rc;
    t_total;
    t_rst_wake;
    complete_run;
  end
endmodule
